// >>> tb/pmbus_host_model.sv
/*
  Host controller model that drives the command port of the register bank.
  Assumes one shared clock and an answer registered on the taking edge.
*/
`timescale 1ns/1ps
module pmbus_host_model
  import vout_limit_pkg::*;
(
  // Clock and answers.
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_refused,
  // Request.
  output cmd_req_t         o_req
);
  // -----------------------------------------------------------------
  // Word access
  // -----------------------------------------------------------------
  initial o_req = '0;

  // Holds one request for one edge, then scrambles the idle fields.
  task automatic access(input logic w, input logic [7:0] c, input logic p,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic rf);
    @(posedge i_ref_clk);
    o_req <= '{wr: w, rd: !w, cmd: c, page: p, wdata: d};
    @(posedge i_ref_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, cmd: ~c, page: ~p, wdata: ~d};
    #1;
    q  = i_rdata;
    rf = i_refused;
  endtask : access
endmodule : pmbus_host_model

// >>> tb/vout_limit_margin_droop_regs_bench.sv
/*
  Self-checking bench for the ceiling, margin and slope register bank.
  Assumes the host model above and fixed strap words on both pins.
*/
`timescale 1ns/1ps
module vout_limit_margin_droop_regs_bench;
  import vout_limit_pkg::*;
  // -----------------------------------------------------------------
  // Signals and expected defaults
  // -----------------------------------------------------------------
  localparam logic [15:0] VS = 16'h2000;
  localparam logic [15:0] SS = 16'hD00A;
  localparam logic [15:0] EC = 16'((32'(VS) * 32'h73) / 32'h64);
  localparam logic [15:0] EU = 16'((32'(VS) * 32'h69) / 32'h64);
  localparam logic [15:0] ED = 16'((32'(VS) * 32'h5F) / 32'h64);
  logic                   ref_clk = 1'b0;
  logic                   resetn  = 1'b0;
  logic                   wp      = 1'b0;
  logic                   clk_en  = 1'b1;
  logic [PAGES-1:0][15:0] target  = '0;
  margin_mode_t           mode [PAGES] = '{MODE_NOMINAL, MODE_NOMINAL};
  cmd_req_t               req;
  logic                   ready, rd_valid, refused, rf;
  logic [15:0]            rdata, q;
  page_out_t [PAGES-1:0]  pout;
  int                     num_errors = 0;
  int                     n_checks   = 0;

  // The clock toggles every half period of 25 ns.
  always #25 ref_clk = ~ref_clk;

  vout_limit_margin_droop_regs u_dut (
    .i_ref_clk(ref_clk), .i_resetn(resetn), .i_clk_en(clk_en),
    .i_voltage_select_strap(VS), .i_slope_strap(SS), .i_req(req),
    .i_write_protect(wp), .i_target_vout(target), .i_margin_mode(mode),
    .o_ready(ready), .o_rd_valid(rd_valid), .o_rdata(rdata),
    .o_refused(refused), .o_page_out(pout));

  pmbus_host_model u_host (.i_ref_clk(ref_clk), .i_rdata(rdata),
    .i_refused(refused), .o_req(req));

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  // Compares one word and counts the result.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Reads a register and expects its value with no refusal.
  task automatic rd(input logic [7:0] c, input logic p,
                    input logic [15:0] exp);
    u_host.access(1'b0, c, p, 16'h0000, q, rf);
    chk(q, exp);
    chk({15'h0000, rf}, 16'h0000);
    chk({15'h0000, rd_valid}, 16'h0001);
  endtask : rd

  // Writes a register and expects the given refusal flag.
  task automatic wr(input logic [7:0] c, input logic p,
                    input logic [15:0] d, input logic exp_rf);
    u_host.access(1'b1, c, p, d, q, rf);
    chk({15'h0000, rf}, {15'h0000, exp_rf});
    chk({15'h0000, rd_valid}, 16'h0000);
  endtask : wr

  // Lets the setpoint path catch up with new inputs.
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  // Waits up to 20 cycles for the defaults to load, sampling off the edge.
  task automatic wait_ready;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({15'h0000, ready}, 16'h0001);
  endtask : wait_ready

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // -----------------------------------------------------------------
  // Tests
  // -----------------------------------------------------------------
  // Main sequence of accesses and setpoint checks.
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_ready;
    for (int p = 0; p < PAGES; p++) begin
      rd(CMD_CEILING, p[0], EC);
      rd(CMD_MARGIN_UP, p[0], EU);
      rd(CMD_MARGIN_DOWN, p[0], ED);
      rd(CMD_SLOPE, p[0], SS);
    end
    settle;
    chk(pout[0].slope, SS);
    wr(CMD_CEILING, 1'b0, 16'h3000, 1'b0);
    @(posedge ref_clk) target <= {16'h2600, 16'h4000};
    settle;
    chk(pout[0].setpoint, 16'h3000);
    chk(pout[1].setpoint, EC);
    rd(CMD_CEILING, 1'b0, 16'h3000);
    @(posedge ref_clk) mode[0] <= MODE_MARGIN_HIGH;
    settle;
    chk(pout[0].setpoint, EU);
    @(posedge ref_clk) mode[0] <= MODE_MARGIN_LOW;
    settle;
    chk(pout[0].setpoint, ED);
    wr(CMD_MARGIN_DOWN, 1'b0, 16'hF000, 1'b0);
    settle;
    chk(pout[0].setpoint, 16'h3000);
    wr(CMD_CEILING, 1'b0, 16'hFFFF, 1'b0);
    settle;
    chk(pout[0].setpoint, 16'hF000);
    @(posedge ref_clk) wp <= 1'b1;
    wr(CMD_SLOPE, 1'b1, 16'h1234, 1'b1);
    @(posedge ref_clk) wp <= 1'b0;
    rd(CMD_SLOPE, 1'b1, SS);
    wr(8'h27, 1'b0, 16'h1234, 1'b1);
    u_host.access(1'b0, 8'h27, 1'b0, 16'h0000, q, rf);
    chk(q, 16'h0000);
    chk({15'h0000, rf}, 16'h0001);
    chk({15'h0000, rd_valid}, 16'h0001);
    wr(CMD_SLOPE, 1'b1, 16'hE814, 1'b0);
    rd(CMD_SLOPE, 1'b1, 16'hE814);
    settle;
    chk(pout[1].slope, 16'hE814);
    // A ceiling write while the enable is low must leave the page 1 ceiling unchanged.
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(CMD_CEILING, 1'b1, 16'h1000, 1'b0);
    @(posedge ref_clk) clk_en <= 1'b1;
    rd(CMD_CEILING, 1'b1, EC);
    // A second reset in mid-run reloads the strap defaults.
    @(posedge ref_clk) resetn <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({15'h0000, ready}, 16'h0000);
    chk(pout[0].setpoint, 16'h0000);
    @(posedge ref_clk) resetn <= 1'b1;
    wait_ready;
    rd(CMD_CEILING, 1'b0, EC);
    rd(CMD_MARGIN_DOWN, 1'b0, ED);
    summarize;
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (2000) @(posedge ref_clk);
    num_errors++;
    summarize;
  end
endmodule : vout_limit_margin_droop_regs_bench

// >>> verilog/vout_limit_margin_droop_regs.sv
/*
  Paged register bank for the output voltage ceiling, the two margin
  setpoints and the load-line slope, plus the effective setpoint clamp.
  Assumes the command engine, page select, write protection, target word
  and margin mode come from logic on i_ref_clk; straps come from pins.
*/
// Functional notes
// [R1] Ceiling bounds every commanded output voltage.
// [R2] Target above ceiling is replaced by ceiling.
// [R3] Ceiling never rescales with target changes.
// [R4] Ceiling is unsigned mantissa, exponent minus 13.
// [R5] Ceiling resets to 1.15 times strap voltage.
// [R6] Host keeps ceiling within 0 to 5.5 V.
// [R7] Margin high mode drives margin-up setpoint.
// [R8] Margin low mode drives margin-down setpoint.
// [R9] Margin-up resets to 1.05 times strap voltage.
// [R10] Margin-down resets to 0.95 times strap voltage.
// [R11] Slope is linear-11 word in mV/A.
// [R12] Host keeps slope within 0 to 40 mV/A.
// [R13] Slope resets from the configuration strap.
// [R14] Host computes slope from combined phase current.
// [R15] Every register exists per page, addressed by page.
// [R16] Protected writes are refused.
// [R17] Margin setpoints are clamped to the ceiling.
// [R18] Margin words are unsigned, exponent minus 13.
`timescale 1ns/1ps
module vout_limit_margin_droop_regs
  import vout_limit_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_clk_en,
  // Strap pins.
  input  wire logic [15:0]            i_voltage_select_strap,
  input  wire logic [15:0]            i_slope_strap,
  // Command port and protection.
  input  wire cmd_req_t               i_req,
  input  wire logic                   i_write_protect,
  // Per-page regulation inputs.
  input  wire logic [PAGES-1:0][15:0] i_target_vout,
  input  wire margin_mode_t           i_margin_mode [PAGES],
  // Answers and per-page outputs.
  output logic                        o_ready,
  output logic                        o_rd_valid,
  output logic [15:0]                 o_rdata,
  output logic                        o_refused,
  output page_out_t [PAGES-1:0]       o_page_out
);

  // -----------------------------------------------------------------------
  // Strap synchronisers and default loading
  // -----------------------------------------------------------------------
  logic [15:0] vsel_meta, vsel_sync, slope_meta, slope_sync;
  logic [1:0]  init_cnt, next_init_cnt;
  logic        loaded, next_loaded;
  logic        load_now;

  // Defaults load once both synchroniser stages hold the strap level.
  always_comb begin
    load_now      = !loaded && (init_cnt == SYNC_WAIT);
    next_init_cnt = (init_cnt == SYNC_WAIT) ? init_cnt : init_cnt + 2'h1;
    next_loaded   = loaded | load_now;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vsel_meta  <= WORD_ZERO;
      vsel_sync  <= WORD_ZERO;
      slope_meta <= WORD_ZERO;
      slope_sync <= WORD_ZERO;
      init_cnt   <= 2'h0;
      loaded     <= 1'b0;
    end else if (i_clk_en) begin
      vsel_meta  <= i_voltage_select_strap;
      vsel_sync  <= vsel_meta;
      slope_meta <= i_slope_strap;
      slope_sync <= slope_meta;
      init_cnt   <= next_init_cnt;
      loaded     <= next_loaded;
    end
  end

  // -----------------------------------------------------------------------
  // Command decode
  // -----------------------------------------------------------------------
  logic mapped, wr_ok;

  // A write lands only when mapped, loaded and not protected.
  always_comb begin
    mapped = (i_req.cmd == CMD_CEILING) || (i_req.cmd == CMD_MARGIN_UP) ||
             (i_req.cmd == CMD_MARGIN_DOWN) || (i_req.cmd == CMD_SLOPE);
    wr_ok  = i_req.wr && mapped && loaded && !i_write_protect; // [R16]
  end

  // -----------------------------------------------------------------------
  // Per-page registers and effective setpoint
  // -----------------------------------------------------------------------
  logic [15:0] ceil_q  [PAGES];
  logic [15:0] up_q    [PAGES];
  logic [15:0] down_q  [PAGES];
  logic [15:0] slope_q [PAGES];

  for (genvar p = 0; p < PAGES; p++) begin : g_page
    logic [15:0] next_ceil, next_up, next_down, next_slope, chosen;
    logic        hit;
    page_out_t   next_out;

    // Defaults at load, then writes addressed to this page only.
    always_comb begin
      hit        = wr_ok && (i_req.page == PAGE_W'(p)); // [R15]
      next_ceil  = ceil_q[p];
      next_up    = up_q[p];
      next_down  = down_q[p];
      next_slope = slope_q[p];
      if (load_now) begin
        next_ceil  = scale_pct(vsel_sync, CEIL_PCT); // [R5]
        next_up    = scale_pct(vsel_sync, UP_PCT);   // [R9]
        next_down  = scale_pct(vsel_sync, DOWN_PCT); // [R10]
        next_slope = slope_sync;                     // [R13]
      end else if (hit) begin
        case (i_req.cmd)
          CMD_CEILING:     next_ceil  = i_req.wdata; // [R3] [R4]
          CMD_MARGIN_UP:   next_up    = i_req.wdata; // [R18]
          CMD_MARGIN_DOWN: next_down  = i_req.wdata; // [R18]
          CMD_SLOPE:       next_slope = i_req.wdata; // [R11]
          default:         next_ceil  = ceil_q[p];
        endcase
      end
    end

    // Mode picks the source, then the unsigned ceiling clamp applies.
    always_comb begin
      case (i_margin_mode[p])
        MODE_MARGIN_HIGH: chosen = up_q[p];      // [R7]
        MODE_MARGIN_LOW:  chosen = down_q[p];    // [R8]
        default:          chosen = i_target_vout[p];
      endcase
      next_out.setpoint = (chosen > ceil_q[p]) ? ceil_q[p] // [R1] [R2]
                                               : chosen;   // [R17]
      next_out.slope    = slope_q[p];
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        ceil_q[p]     <= WORD_ZERO;
        up_q[p]       <= WORD_ZERO;
        down_q[p]     <= WORD_ZERO;
        slope_q[p]    <= WORD_ZERO;
        o_page_out[p] <= '0;
      end else if (i_clk_en) begin
        ceil_q[p]     <= next_ceil;
        up_q[p]       <= next_up;
        down_q[p]     <= next_down;
        slope_q[p]    <= next_slope;
        o_page_out[p] <= next_out;
      end
    end

    // Checks on the clamp, mode selection and storage of this page.
    ceil_clamp_a: assert property ( // [R1]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_clk_en |=> o_page_out[p].setpoint <= $past(ceil_q[p]))
      else $error("Setpoint above ceiling.");
    target_pass_a: assert property ( // [R2]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_clk_en && i_margin_mode[p] == MODE_NOMINAL |=>
        o_page_out[p].setpoint == (($past(i_target_vout[p]) > $past(ceil_q[p]))
          ? $past(ceil_q[p]) : $past(i_target_vout[p])))
      else $error("Nominal setpoint wrong.");
    margin_up_a: assert property ( // [R7]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_clk_en && i_margin_mode[p] == MODE_MARGIN_HIGH &&
        up_q[p] <= ceil_q[p] |=> o_page_out[p].setpoint == $past(up_q[p]))
      else $error("Margin high setpoint wrong.");
    margin_down_a: assert property ( // [R8]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_clk_en && i_margin_mode[p] == MODE_MARGIN_LOW &&
        down_q[p] <= ceil_q[p] |=> o_page_out[p].setpoint == $past(down_q[p]))
      else $error("Margin low setpoint wrong.");
    ceil_keep_a: assert property ( // [R3]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !load_now && !(hit && i_req.cmd == CMD_CEILING) |=> $stable(ceil_q[p]))
      else $error("Ceiling changed without a write.");
    ceil_default_a: assert property ( // [R5]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_clk_en && load_now |=>
        ceil_q[p] == scale_pct($past(vsel_sync), CEIL_PCT) &&
        up_q[p] == scale_pct($past(vsel_sync), UP_PCT))
      else $error("Ceiling or margin default wrong.");
    slope_default_a: assert property ( // [R13]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_clk_en && load_now |=> slope_q[p] == $past(slope_sync))
      else $error("Slope default wrong.");
    protect_hold_a: assert property ( // [R16]
      @(posedge i_ref_clk) disable iff (!i_resetn)
      loaded && i_req.wr && i_write_protect |=> $stable(ceil_q[p]) &&
        $stable(up_q[p]) && $stable(down_q[p]) && $stable(slope_q[p]))
      else $error("Protected write changed a register.");
  end

  // -----------------------------------------------------------------------
  // Read path and answer flags
  // -----------------------------------------------------------------------
  logic [15:0] next_rdata;
  logic        next_rd_valid, next_refused;

  // Reads return the selected page's instance; unmapped reads give zero.
  always_comb begin
    case (i_req.cmd)
      CMD_CEILING:     next_rdata = ceil_q[i_req.page];  // [R15]
      CMD_MARGIN_UP:   next_rdata = up_q[i_req.page];
      CMD_MARGIN_DOWN: next_rdata = down_q[i_req.page];
      CMD_SLOPE:       next_rdata = slope_q[i_req.page];
      default:         next_rdata = WORD_ZERO;
    endcase
    if (!i_req.rd) begin
      next_rdata = o_rdata;
    end
    next_rd_valid = i_req.rd;
    next_refused  = (i_req.wr && !wr_ok) ||
                    (i_req.rd && (!mapped || !loaded)); // [R16]
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata    <= WORD_ZERO;
      o_rd_valid <= 1'b0;
      o_refused  <= 1'b0;
      o_ready    <= 1'b0;
    end else if (i_clk_en) begin
      o_rdata    <= next_rdata;
      o_rd_valid <= next_rd_valid;
      o_refused  <= next_refused;
      o_ready    <= next_loaded;
    end
  end

  read_back_a: assert property ( // [R15]
    @(posedge i_ref_clk) disable iff (!i_resetn)
    i_clk_en && i_req.rd && i_req.cmd == CMD_CEILING |=>
      o_rd_valid && o_rdata == $past(ceil_q[i_req.page]))
    else $error("Ceiling read-back wrong.");
  refuse_flag_a: assert property ( // [R16]
    @(posedge i_ref_clk) disable iff (!i_resetn)
    i_clk_en && i_req.wr && i_write_protect |=> o_refused)
    else $error("Protected write not flagged.");

endmodule : vout_limit_margin_droop_regs

// >>> verilog/vout_limit_pkg.sv
/*
  Constants, command codes and carrier types for the output voltage
  ceiling, margin and load-line register bank.
  Assumes a command engine on the same clock that decodes the bus framing
  and presents one word-wide request per command.
*/
package vout_limit_pkg;

  // ---------------------------------------------------------------------
  // Sizes and command codes
  // ---------------------------------------------------------------------
  localparam int         PAGES           = 2;
  localparam int         PAGE_W          = 1;
  localparam logic [7:0] CMD_CEILING     = 8'h24;
  localparam logic [7:0] CMD_MARGIN_UP   = 8'h25;
  localparam logic [7:0] CMD_MARGIN_DOWN = 8'h26;
  localparam logic [7:0] CMD_SLOPE       = 8'h28;

  // Voltage words are unsigned mantissas scaled by two to this power.
  localparam int         VOUT_EXP        = -13;

  // ---------------------------------------------------------------------
  // Strap-derived defaults, in percent of the selected voltage
  // ---------------------------------------------------------------------
  localparam logic [7:0]  CEIL_PCT  = 8'h73;
  localparam logic [7:0]  UP_PCT    = 8'h69;
  localparam logic [7:0]  DOWN_PCT  = 8'h5F;
  localparam logic [23:0] PCT_DIV   = 24'h000064;
  localparam logic [1:0]  SYNC_WAIT = 2'h2;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_FULL = 16'hFFFF;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NOMINAL,
    MODE_MARGIN_LOW,
    MODE_MARGIN_HIGH
  } margin_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [7:0]        cmd;
    logic [PAGE_W-1:0] page;
    logic [15:0]       wdata;
  } cmd_req_t;

  typedef struct packed {
    logic [15:0] setpoint;
    logic [15:0] slope;
  } page_out_t;

  // Scales a voltage word by a percentage and saturates to 16 bits.
  function automatic logic [15:0] scale_pct(input logic [15:0] v,
                                            input logic [7:0]  pct);
    logic [23:0] prod;
    prod = ({8'h00, v} * {16'h0000, pct}) / PCT_DIV;
    scale_pct = (prod[23:16] != 8'h00) ? WORD_FULL : prod[15:0];
  endfunction : scale_pct

endpackage : vout_limit_pkg
